//--- logic/rxsf_pkg.sv
// Constants, field layouts and reset values of the receive stamp filter block.
// Assumes a 16-bit register port addressed by 5-bit register numbers.
package rxsf_pkg;

  // Register numbers on the management port.
  localparam logic [4:0] ADDR_BASE_CFG = 5'h18;
  localparam logic [4:0] ADDR_STATUS = 5'h19;
  localparam logic [4:0] ADDR_IP_HALF = 5'h1B;
  localparam logic [4:0] ADDR_EXT_CFG = 5'h1C;

  // Base configuration bits.
  localparam int BASE_DOMAIN_EN = 15;
  localparam int BASE_IP_SEL = 13;
  localparam int BASE_IP_EN = 12;

  // Extended configuration fields.
  localparam int EXT_MIN_GAP_LSB = 12;
  localparam int EXT_KEEP_UDP = 11;
  localparam int EXT_KEEP_CRC = 10;
  localparam int EXT_APPEND = 9;
  localparam int EXT_INSERT = 8;
  localparam int EXT_DOMAIN_LSB = 0;

  // Status fields.
  localparam int STAT_CAPTURE = 0;
  localparam int STAT_INSERT = 1;
  localparam int STAT_DISCARD = 2;
  localparam int STAT_DROP_LSB = 8;

  // Reset values.
  localparam logic [15:0] BASE_CFG_RESET = 16'h0000;
  localparam logic [15:0] IP_HALF_RESET = 16'h0000;
  localparam logic [3:0] MIN_GAP_RESET = 4'hC;
  localparam logic [3:0] GAP_SATURATE = 4'hF;
  localparam logic [7:0] DOMAIN_RESET = 8'h00;

  // Buffer geometry: two entries of {preamble, last, data}.
  localparam int BUF_DEPTH = 2;
  localparam int BEAT_W = 10;

  // Gap tracking states toward the MAC.
  typedef enum logic {
    RXSF_GAP,
    RXSF_FRAME
  } rxsf_gap_state_t;

endpackage

//--- logic/rxsf_top.sv
// Receive stamp filter: register file, stamp eligibility decision and gap keeper toward the MAC.
// Assumes the parser and the MAC side run on the same clock; one accepted beat is one byte time.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns

module rxsf_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_pre,
  input wire logic in_last,
  input wire logic in_event,
  input wire logic in_is_udp,
  input wire logic in_is_l2,
  input wire logic [31:0] in_dest_ip,
  input wire logic [7:0] in_domain,
  input wire logic in_udp_err,
  input wire logic in_crc_err,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic stamp_capture,
  output logic stamp_insert,
  output logic stamp_append
);

  // Configuration state.
  logic domain_match_on;
  logic ip_half_select;
  logic user_ip_filter_on;
  logic [31:0] filter_ip;
  logic [3:0] min_gap_byte_times;
  logic keep_on_udp_sum_error;
  logic keep_on_frame_check_error;
  logic append_stamp_layer2;
  logic stamp_into_packet;
  logic [7:0] domain_match_value;

  // Decision and gap state.
  logic stamp_discard;
  logic [7:0] drop_count;
  localparam int BEAT_W_LOCAL = rxsf_pkg::BEAT_W;
  logic [BEAT_W_LOCAL-1:0] buf_mem [rxsf_pkg::BUF_DEPTH];
  logic buf_wr_ptr;
  logic buf_rd_ptr;
  logic [1:0] buf_count;
  logic [3:0] gap_count;
  rxsf_pkg::rxsf_gap_state_t gap_state;

  // Combinational helpers.
  logic [15:0] ext_cfg_view;
  logic [15:0] base_cfg_view;
  logic [15:0] next_rdata;
  logic push;
  logic pop;
  logic head_pre;
  logic head_last;
  logic [7:0] head_data;
  logic drop_head;
  logic frame_end;
  logic [3:0] gap_seen;
  logic take_last;
  logic ip_ok;
  logic domain_ok;
  logic error_ok;
  logic eligible;
  logic [1:0] next_count;

  // Register views, assembled once and used only by the read mux.
  always_comb begin
    base_cfg_view = 16'h0000;
    base_cfg_view[rxsf_pkg::BASE_DOMAIN_EN] = domain_match_on;
    base_cfg_view[rxsf_pkg::BASE_IP_SEL] = ip_half_select;
    base_cfg_view[rxsf_pkg::BASE_IP_EN] = user_ip_filter_on;
    ext_cfg_view = {min_gap_byte_times, keep_on_udp_sum_error, keep_on_frame_check_error,
                    append_stamp_layer2, stamp_into_packet, domain_match_value};
  end

  // Base configuration; domain matching starts disabled so no domain is checked unbidden.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      domain_match_on <= rxsf_pkg::BASE_CFG_RESET[rxsf_pkg::BASE_DOMAIN_EN];
      ip_half_select <= rxsf_pkg::BASE_CFG_RESET[rxsf_pkg::BASE_IP_SEL];
      user_ip_filter_on <= rxsf_pkg::BASE_CFG_RESET[rxsf_pkg::BASE_IP_EN];
    end else if (reg_wr && reg_addr == rxsf_pkg::ADDR_BASE_CFG) begin
      domain_match_on <= reg_wdata[rxsf_pkg::BASE_DOMAIN_EN];
      ip_half_select <= reg_wdata[rxsf_pkg::BASE_IP_SEL];
      user_ip_filter_on <= reg_wdata[rxsf_pkg::BASE_IP_EN];
    end
  end

  // Filter address: the selector picks which half a write lands in.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      filter_ip <= {rxsf_pkg::IP_HALF_RESET, rxsf_pkg::IP_HALF_RESET};
    end else if (reg_wr && reg_addr == rxsf_pkg::ADDR_IP_HALF) begin
      if (!ip_half_select) begin
        filter_ip[31:16] <= reg_wdata;
      end else begin
        filter_ip[15:0] <= reg_wdata;
      end
    end
  end

  // Extended configuration; the gap minimum is writable so software can tune it to the MAC.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      min_gap_byte_times <= rxsf_pkg::MIN_GAP_RESET;
      keep_on_udp_sum_error <= 1'h0;
      keep_on_frame_check_error <= 1'h0;
      append_stamp_layer2 <= 1'h0;
      stamp_into_packet <= 1'h0;
      domain_match_value <= rxsf_pkg::DOMAIN_RESET;
    end else if (reg_wr && reg_addr == rxsf_pkg::ADDR_EXT_CFG) begin
      min_gap_byte_times <= reg_wdata[rxsf_pkg::EXT_MIN_GAP_LSB +: 4];
      keep_on_udp_sum_error <= reg_wdata[rxsf_pkg::EXT_KEEP_UDP];
      keep_on_frame_check_error <= reg_wdata[rxsf_pkg::EXT_KEEP_CRC];
      append_stamp_layer2 <= reg_wdata[rxsf_pkg::EXT_APPEND];
      stamp_into_packet <= reg_wdata[rxsf_pkg::EXT_INSERT];
      domain_match_value <= reg_wdata[rxsf_pkg::EXT_DOMAIN_LSB +: 8];
    end
  end

  // Read mux; an unmapped register reads as zero.
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr)
      rxsf_pkg::ADDR_BASE_CFG: next_rdata = base_cfg_view;
      rxsf_pkg::ADDR_IP_HALF: next_rdata = ip_half_select ? filter_ip[15:0] :
                                                            filter_ip[31:16];
      rxsf_pkg::ADDR_EXT_CFG: next_rdata = ext_cfg_view;
      rxsf_pkg::ADDR_STATUS: begin
        next_rdata[rxsf_pkg::STAT_CAPTURE] = stamp_capture;
        next_rdata[rxsf_pkg::STAT_INSERT] = stamp_insert;
        next_rdata[rxsf_pkg::STAT_DISCARD] = stamp_discard;
        next_rdata[rxsf_pkg::STAT_DROP_LSB +: 8] = drop_count;
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Eligibility of the packet ending on this beat.
  always_comb begin
    take_last = in_valid && in_ready && in_last;
    ip_ok = !user_ip_filter_on || !in_is_udp || (in_dest_ip == filter_ip);
    domain_ok = !domain_match_on || (in_domain == domain_match_value);
    error_ok = (!in_udp_err || keep_on_udp_sum_error)
               && (!in_crc_err || keep_on_frame_check_error);
    eligible = in_event && ip_ok && domain_ok && error_ok;
  end

  // Decision pulses; insertion steers the stamp away from the stamp register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stamp_capture <= 1'h0;
      stamp_insert <= 1'h0;
      stamp_append <= 1'h0;
      stamp_discard <= 1'h0;
    end else begin
      stamp_capture <= take_last && eligible && !stamp_into_packet;
      stamp_insert <= take_last && eligible && stamp_into_packet;
      stamp_append <= take_last && eligible && stamp_into_packet
                      && append_stamp_layer2 && in_is_l2;
      stamp_discard <= take_last && in_event && !eligible;
    end
  end

  // Two-entry buffer between the parser and the MAC side.
  always_comb begin
    push = in_valid && in_ready;
    {head_pre, head_last, head_data} = buf_mem[buf_rd_ptr];
    pop = (buf_count != 2'h0) && (!out_valid || out_ready);
    frame_end = out_valid && out_ready && out_last;
    gap_seen = (gap_state == rxsf_pkg::RXSF_GAP) ? gap_count : 4'h0;
    drop_head = pop && head_pre && (gap_state == rxsf_pkg::RXSF_GAP || frame_end)
                && gap_seen < min_gap_byte_times;
    next_count = buf_count + {1'b0, push} - {1'b0, pop};
  end

  // Buffer storage, one flip-flop word per entry.
  for (genvar i = 0; i < rxsf_pkg::BUF_DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        buf_mem[i] <= '0;
      end else if (push && buf_wr_ptr == i[0]) begin
        buf_mem[i] <= {in_pre, in_last, in_data};
      end
    end
  end

  // Buffer pointers and ready; ready falls when full so a MAC stall loses nothing.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      buf_wr_ptr <= 1'h0;
      buf_rd_ptr <= 1'h0;
      buf_count <= 2'h0;
      in_ready <= 1'h0;
    end else begin
      buf_wr_ptr <= buf_wr_ptr ^ push;
      buf_rd_ptr <= buf_rd_ptr ^ pop;
      buf_count <= next_count;
      in_ready <= next_count != 2'h2;
    end
  end

  // Output stage toward the MAC; a dropped preamble byte leaves a byte time empty.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'h0;
      out_data <= 8'h00;
      out_last <= 1'h0;
    end else if (pop) begin
      out_valid <= !drop_head;
      out_data <= head_data;
      out_last <= head_last;
    end else if (out_ready) begin
      out_valid <= 1'h0;
    end
  end

  // Gap tracking: counts idle byte times after a frame, closed by the next byte sent.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_state <= rxsf_pkg::RXSF_GAP;
      gap_count <= rxsf_pkg::GAP_SATURATE;
    end else begin
      unique case (gap_state)
        rxsf_pkg::RXSF_GAP: begin
          if (pop && !drop_head) begin
            gap_state <= rxsf_pkg::RXSF_FRAME;
          end else if (!out_valid && gap_count != rxsf_pkg::GAP_SATURATE) begin
            gap_count <= gap_count + 4'h1;
          end
        end
        rxsf_pkg::RXSF_FRAME: begin
          if (frame_end) begin
            gap_count <= 4'h0;
            if (!pop || drop_head) begin
              gap_state <= rxsf_pkg::RXSF_GAP;
            end
          end
        end
      endcase
    end
  end

  // Dropped preamble counter, saturating so software sees a lasting trace.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      drop_count <= 8'h00;
    end else if (drop_head && drop_count != 8'hFF) begin
      drop_count <= drop_count + 8'h01;
    end
  end

  // Checks on the decision path, the gap keeper and the register file.
  sequence s_end_taken;
    in_valid && in_ready && in_last && in_event;
  endsequence

  property p_half_write;
    @(posedge clock) disable iff (!rstn)
      reg_wr && reg_addr == rxsf_pkg::ADDR_IP_HALF && !ip_half_select
      |=> filter_ip[31:16] == $past(reg_wdata);
  endproperty
  a_half_write: assert property (p_half_write) else $error("Upper half not written.");

  property p_half_read;
    @(posedge clock) disable iff (!rstn)
      reg_rd && reg_addr == rxsf_pkg::ADDR_IP_HALF && !reg_wr
      |=> reg_rdata == ($past(ip_half_select) ? filter_ip[15:0] : filter_ip[31:16]);
  endproperty
  a_half_read: assert property (p_half_read) else $error("Address half read wrong.");

  property p_ip_miss;
    @(posedge clock) disable iff (!rstn)
      s_end_taken ##0 (user_ip_filter_on && in_is_udp && in_dest_ip != filter_ip)
      |=> !stamp_capture && !stamp_insert;
  endproperty
  a_ip_miss: assert property (p_ip_miss) else $error("Stamp kept on address miss.");

  property p_udp_err;
    @(posedge clock) disable iff (!rstn)
      s_end_taken ##0 (in_udp_err && !keep_on_udp_sum_error) |=> !stamp_capture && !stamp_insert;
  endproperty
  a_udp_err: assert property (p_udp_err) else $error("Stamp kept on checksum error.");

  property p_crc_err;
    @(posedge clock) disable iff (!rstn)
      s_end_taken ##0 (in_crc_err && !keep_on_frame_check_error)
      |=> !stamp_capture && !stamp_insert;
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("Stamp kept on frame error.");

  property p_append;
    @(posedge clock) disable iff (!rstn)
      stamp_append |-> stamp_insert && $past(append_stamp_layer2) && $past(in_is_l2);
  endproperty
  a_append: assert property (p_append) else $error("Append without insertion.");

  property p_insert_excl;
    @(posedge clock) disable iff (!rstn)
      stamp_insert |-> !stamp_capture && $past(stamp_into_packet);
  endproperty
  a_insert_excl: assert property (p_insert_excl) else $error("Inserted stamp also captured.");

  property p_domain;
    @(posedge clock) disable iff (!rstn)
      s_end_taken ##0 (domain_match_on && in_domain != domain_match_value)
      |=> !stamp_capture && !stamp_insert;
  endproperty
  a_domain: assert property (p_domain) else $error("Stamp kept on domain miss.");

  property p_gap_drop;
    @(posedge clock) disable iff (!rstn)
      pop && head_pre && gap_state == rxsf_pkg::RXSF_GAP && gap_count < min_gap_byte_times
      |=> !out_valid ##0 drop_count != 8'h00;
  endproperty
  a_gap_drop: assert property (p_gap_drop) else $error("Preamble sent inside short gap.");

  property p_domain_reset;
    @(posedge clock) $rose(rstn) |-> !domain_match_on;
  endproperty
  a_domain_reset: assert property (p_domain_reset) else $error("Domain match on at reset.");

endmodule

//--- verif/rxsf_mac_model.sv
// MAC model that takes the byte stream leaving the stamp filter.
// Assumes one clock shared with the filter; slow mode stalls on every other cycle.
`timescale 1ns/1ns
module rxsf_mac_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready,
  output int nbytes,
  output int nframes,
  output logic [7:0] last_data
);
  logic phase;

  // Ready toggles in slow mode so that the filter's two-entry buffer fills up.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      phase <= ~phase;
      out_ready <= slow ? phase : 1'b1;
    end
  end

  // Every accepted byte and every frame end is counted for the bench.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nbytes <= 0;
      nframes <= 0;
      last_data <= 8'h00;
    end else if (out_valid && out_ready) begin
      nbytes <= nbytes + 1;
      if (out_last === 1'b1) begin
        nframes <= nframes + 1;
        last_data <= out_data;
      end
    end
  end
endmodule

//--- verif/tb_rxsf_top.sv
// Self-checking bench for the receive stamp filter.
// Assumes the MAC model file is compiled first and one 50 MHz clock.
`timescale 1ns/1ns
module tb_rxsf_top;
  logic clock, rstn, reg_wr, reg_rd, in_valid, in_ready, in_pre, in_last, in_event;
  logic in_is_udp, in_is_l2, in_udp_err, in_crc_err, out_valid, out_ready, out_last;
  logic stamp_capture, stamp_insert, stamp_append, slow;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [7:0] in_data, in_domain, out_data, last_data;
  logic [31:0] in_dest_ip;
  int failures, cmp_count, cyc, ncap, nins, napp, nbytes, nframes, b0, d0, f0;

  rxsf_top dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_pre(in_pre), .in_last(in_last),
    .in_event(in_event), .in_is_udp(in_is_udp), .in_is_l2(in_is_l2), .in_dest_ip(in_dest_ip),
    .in_domain(in_domain), .in_udp_err(in_udp_err), .in_crc_err(in_crc_err),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .stamp_capture(stamp_capture), .stamp_insert(stamp_insert), .stamp_append(stamp_append));
  rxsf_mac_model mac (.clock(clock), .rstn(rstn), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready), .nbytes(nbytes),
    .nframes(nframes), .last_data(last_data));

  // Clock and the hang guard; the ceiling is far above the few hundred cycles needed.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (stamp_capture === 1'b1) ncap++;
    if (stamp_insert === 1'b1) nins++;
    if (stamp_append === 1'b1) napp++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // One event packet: npre preamble bytes, two body bytes; fl is {udp, l2, udp err, crc err}.
  task automatic pk(input logic [31:0] ip, input logic [7:0] dom, input logic [3:0] fl,
                    input int npre, input logic [2:0] exp);
    logic ok;
    ncap = 0;
    nins = 0;
    napp = 0;
    @(posedge clock);
    for (int i = 0; i < npre + 2; i++) begin
      in_valid <= 1'b1;
      in_data <= 8'(i);
      in_pre <= (i < npre);
      in_last <= (i == npre + 1);
      {in_is_udp, in_is_l2, in_udp_err, in_crc_err} <= fl;
      in_dest_ip <= ip;
      in_domain <= dom;
      do begin
        #1 ok = in_ready;
        @(posedge clock);
      end while (ok !== 1'b1);
    end
    in_valid <= 1'b0;
    if (exp !== 3'h7) begin
      repeat (4) @(posedge clock);
      chk(16'({ncap[0], nins[0], napp[0]}), 16'(exp));
    end
  endtask

  task automatic s_reset();
    rd(5'h18, v); chk(v, 16'h0000);
    rd(5'h1B, v); chk(v, 16'h0000);
    rd(5'h1C, v); chk(v, 16'hC000);
    rd(5'h19, v); chk(v, 16'h0000);
    rd(5'h05, v); chk(v, 16'h0000);
  endtask

  // Address halves are written with the selector switched between them.
  task automatic s_ip();
    wr(5'h18, 16'h0000); wr(5'h1B, 16'hE000);
    wr(5'h18, 16'h2000); wr(5'h1B, 16'h0181);
    rd(5'h1B, v); chk(v, 16'h0181);
    wr(5'h18, 16'h0000);
    rd(5'h1B, v); chk(v, 16'hE000);
  endtask

  task automatic s_filter();
    wr(5'h18, 16'h1000);
    slow <= 1'b1;
    pk(32'hE0000181, 8'h07, 4'h8, 1, 3'h4);
    pk(32'hE0000180, 8'h07, 4'h8, 1, 3'h0);
    pk(32'hE1000181, 8'h07, 4'h8, 1, 3'h0);
    pk(32'h0A000001, 8'h07, 4'h0, 1, 3'h4);
    slow <= 1'b0;
  endtask

  task automatic s_err();
    pk(32'hE0000181, 8'h00, 4'hA, 1, 3'h0);
    wr(5'h1C, 16'hC800);
    pk(32'hE0000181, 8'h00, 4'hA, 1, 3'h4);
    pk(32'hE0000181, 8'h00, 4'h9, 1, 3'h0);
    wr(5'h1C, 16'hC400);
    pk(32'hE0000181, 8'h00, 4'h9, 1, 3'h4);
  endtask

  task automatic s_ins();
    wr(5'h1C, 16'hC100);
    pk(32'hE0000181, 8'h00, 4'h4, 1, 3'h2);
    wr(5'h1C, 16'hC300);
    pk(32'hE0000181, 8'h00, 4'h4, 1, 3'h3);
    wr(5'h1C, 16'hC200);
    pk(32'hE0000181, 8'h00, 4'h4, 1, 3'h4);
  endtask

  task automatic s_dom();
    wr(5'h18, 16'h8000);
    wr(5'h1C, 16'hC005);
    pk(32'h0, 8'h05, 4'h4, 1, 3'h4);
    pk(32'h0, 8'h06, 4'h4, 1, 3'h0);
    // A packet that is not an event message never earns a stamp.
    in_event <= 1'b0;
    pk(32'h0, 8'h05, 4'h4, 1, 3'h0);
    in_event <= 1'b1;
  endtask

  // Back-to-back packets: dropped preamble plus delivered bytes must add up to all sent.
  task automatic s_gap();
    wr(5'h1C, 16'hC000);
    repeat (20) @(posedge clock);
    rd(5'h19, v);
    d0 = v[15:8];
    b0 = nbytes;
    f0 = nframes;
    pk(32'h0, 8'h00, 4'h4, 3, 3'h7);
    pk(32'h0, 8'h00, 4'h4, 3, 3'h7);
    repeat (20) @(posedge clock);
    rd(5'h19, v);
    chk(16'(v[15:8] > d0), 16'h0001);
    chk(16'(nbytes - b0 + v[15:8] - d0), 16'h000A);
    chk(16'(nframes - f0), 16'h0002);
    chk(16'(last_data), 16'h0004);
    d0 = v[15:8];
    b0 = nbytes;
    wr(5'h1C, 16'h0000);
    pk(32'h0, 8'h00, 4'h4, 3, 3'h7);
    pk(32'h0, 8'h00, 4'h4, 3, 3'h7);
    repeat (20) @(posedge clock);
    rd(5'h19, v);
    chk(16'(v[15:8]), 16'(d0));
    chk(16'(nbytes - b0), 16'h000A);
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    {rstn, reg_wr, reg_rd, in_valid, in_pre, in_last, in_is_udp, in_is_l2} = '0;
    {in_udp_err, in_crc_err, slow} = '0;
    in_event = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    in_data = '0;
    in_domain = '0;
    in_dest_ip = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    s_reset();
    s_ip();
    s_filter();
    s_err();
    s_ins();
    s_dom();
    s_gap();
    end_sim();
  end
endmodule
